// *** hdl/mp3_ctrl_pkg.sv ***
package mp3_ctrl_pkg;

    // ***************************************************************
    // Register addresses on the core register bus
    // ***************************************************************
    localparam logic [7:0] ADDR_VOLUME_LEFT   = 8'h9E;
    localparam logic [7:0] ADDR_VOLUME_RIGHT  = 8'h9F;
    localparam logic [7:0] ADDR_ANCILLARY     = 8'hAD;
    localparam logic [7:0] ADDR_BASS_GAIN     = 8'hB4;
    localparam logic [7:0] ADDR_MEDIUM_GAIN   = 8'hB5;
    localparam logic [7:0] ADDR_TREBLE_GAIN   = 8'hB6;
    localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'hEB;

    // ***************************************************************
    // Field layout and reset values
    // ***************************************************************
    localparam int          FIELD_W      = 5;
    localparam int          BYTE_W       = 8;
    localparam logic [4:0]  FIELD_RESET  = 5'h00;
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    localparam logic [2:0]  UPPER_ZERO   = 3'h0;
    localparam logic [4:0]  DIV_ONE      = 5'h01;

endpackage : mp3_ctrl_pkg

// *** hdl/mp3_decoder_control_regs.sv ***
`timescale 1ns/1ps

module mp3_decoder_control_regs
    import mp3_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rstn,
    input  wire logic                clkEn,
    // Register bus
    input  wire logic                regSel,
    input  wire logic                regWr,
    input  wire logic                regRd,
    input  wire logic [7:0]          regAddr,
    input  wire logic [7:0]          regWdata,
    output logic      [7:0]          regRdata,
    // Ancillary buffer from decoder
    input  wire logic                ancValid,
    input  wire logic [BYTE_W-1:0]   ancByte,
    output logic                     ancPop,
    // Decoder step strobe, settings are latched on it
    input  wire logic                decStep,
    // Settings toward the decoder datapath
    output logic [FIELD_W-1:0]       leftLevel,
    output logic [FIELD_W-1:0]       rightLevel,
    output logic [FIELD_W-1:0]       lowBandGain,
    output logic [FIELD_W-1:0]       midBandGain,
    output logic [FIELD_W-1:0]       highBandGain,
    output logic                     ancillaryAvailableFlag,
    output logic                     decClkEn
);

    // ***************************************************************
    // Register file
    // ***************************************************************
    logic [FIELD_W-1:0] left_reg;
    logic [FIELD_W-1:0] right_reg;
    logic [FIELD_W-1:0] bass_reg;
    logic [FIELD_W-1:0] mid_reg;
    logic [FIELD_W-1:0] treble_reg;
    logic [FIELD_W-1:0] clkdiv_reg;
    logic [FIELD_W-1:0] divCnt_reg;
    logic               wrEn;
    logic               rdEn;

    assign wrEn = clkEn && regSel && regWr;
    assign rdEn = clkEn && regSel && regRd;

    // Shared address match, used by every register and by the ancillary pop
    function automatic logic addrHit(input logic [BYTE_W-1:0] busAddr,
                                     input logic [BYTE_W-1:0] regOffset);
        addrHit = (busAddr == regOffset);
    endfunction : addrHit

    // Pads a field to a bus byte with the unused upper bits cleared
    function automatic logic [BYTE_W-1:0] padField(input logic [FIELD_W-1:0] field);
        padField = {UPPER_ZERO, field};
    endfunction : padField

    // Upper bits are dropped on write, so the field never holds them.
    // Writes to the ancillary byte or an unmapped address reach no register
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            left_reg <= FIELD_RESET;
        end
        else if (wrEn && addrHit(regAddr, ADDR_VOLUME_LEFT))
        begin
            left_reg <= regWdata[FIELD_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            right_reg <= FIELD_RESET;
        end
        else if (wrEn && addrHit(regAddr, ADDR_VOLUME_RIGHT))
        begin
            right_reg <= regWdata[FIELD_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            bass_reg <= FIELD_RESET;
        end
        else if (wrEn && addrHit(regAddr, ADDR_BASS_GAIN))
        begin
            bass_reg <= regWdata[FIELD_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            mid_reg <= FIELD_RESET;
        end
        else if (wrEn && addrHit(regAddr, ADDR_MEDIUM_GAIN))
        begin
            mid_reg <= regWdata[FIELD_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            treble_reg <= FIELD_RESET;
        end
        else if (wrEn && addrHit(regAddr, ADDR_TREBLE_GAIN))
        begin
            treble_reg <= regWdata[FIELD_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            clkdiv_reg <= FIELD_RESET;
        end
        else if (wrEn && addrHit(regAddr, ADDR_CLOCK_DIVIDER))
        begin
            clkdiv_reg <= regWdata[FIELD_W-1:0];
        end
    end

    // ***************************************************************
    // Read path
    // ***************************************************************
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            regRdata <= BYTE_RESET;
        end
        else if (rdEn)
        begin
            unique case (regAddr)
                ADDR_VOLUME_LEFT:   regRdata <= padField(left_reg);
                ADDR_VOLUME_RIGHT:  regRdata <= padField(right_reg);
                ADDR_BASS_GAIN:     regRdata <= padField(bass_reg);
                ADDR_MEDIUM_GAIN:   regRdata <= padField(mid_reg);
                ADDR_TREBLE_GAIN:   regRdata <= padField(treble_reg);
                ADDR_CLOCK_DIVIDER: regRdata <= padField(clkdiv_reg);
                ADDR_ANCILLARY:     regRdata <= ancValid ? ancByte : BYTE_RESET;
                default:            regRdata <= BYTE_RESET;
            endcase
        end
    end

    // A read of the ancillary byte consumes it from the decoder buffer
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ancPop <= 1'h0;
        end
        else if (clkEn)
        begin
            ancPop <= rdEn && addrHit(regAddr, ADDR_ANCILLARY) && ancValid;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ancillaryAvailableFlag <= 1'h0;
        end
        else if (clkEn)
        begin
            ancillaryAvailableFlag <= ancValid;
        end
    end

    // ***************************************************************
    // Settings handed to the decoder at its step boundary
    // ***************************************************************
    // Latching on the step keeps a half-written setting out of a running sample
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            leftLevel    <= FIELD_RESET;
            rightLevel   <= FIELD_RESET;
            lowBandGain  <= FIELD_RESET;
            midBandGain  <= FIELD_RESET;
            highBandGain <= FIELD_RESET;
        end
        else if (clkEn && decStep)
        begin
            leftLevel    <= left_reg;
            rightLevel   <= right_reg;
            lowBandGain  <= bass_reg;
            midBandGain  <= mid_reg;
            highBandGain <= treble_reg;
        end
    end

    // ***************************************************************
    // Decoder clock divider: one enable pulse every (value + 1) cycles
    // ***************************************************************
    // A new value is compared against at once, the divider never restarts; a count already past it wraps on the next cycle
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            divCnt_reg <= FIELD_RESET;
            decClkEn   <= 1'h0;
        end
        else if (clkEn)
        begin
            if (divCnt_reg >= clkdiv_reg)
            begin
                divCnt_reg <= FIELD_RESET;
                decClkEn   <= 1'h1;
            end
            else
            begin
                divCnt_reg <= divCnt_reg + DIV_ONE;
                decClkEn   <= 1'h0;
            end
        end
    end

endmodule : mp3_decoder_control_regs

// *** verif/mp3_ctrl_monitor.sv ***
`timescale 1ns/1ps
// ****
// Port checker for the control register bank
// ****
module mp3_ctrl_monitor
    import mp3_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rstn,
    input wire logic       clkEn,
    // Register bus
    input wire logic       regSel,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    // Ancillary buffer and decoder side
    input wire logic       ancValid,
    input wire logic [7:0] ancByte,
    input wire logic       ancPop,
    input wire logic       decStep,
    input wire logic [4:0] leftLevel,
    input wire logic       ancillaryAvailableFlag,
    input wire logic       decClkEn
);
    logic       rdEn;
    logic       wrEn;
    logic [4:0] divReg;
    assign rdEn = clkEn && regSel && regRd;
    assign wrEn = clkEn && regSel && regWr;
    // Shadow of the divider, so pulse spacing can be judged
    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            divReg <= 5'h00;
        else if (wrEn && regAddr == ADDR_CLOCK_DIVIDER)
            divReg <= regWdata[4:0];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_upper_zero: assert property (rdEn && regAddr != ADDR_ANCILLARY |=>
        regRdata[7:5] == 3'h0) else $error("upper bits read nonzero");
    a_anc_read: assert property (rdEn && regAddr == ADDR_ANCILLARY && ancValid |=>
        regRdata == $past(ancByte) && ancPop) else $error("ancillary read wrong");
    a_anc_empty: assert property (rdEn && regAddr == ADDR_ANCILLARY && !ancValid |=>
        regRdata == 8'h00 && !ancPop) else $error("empty ancillary read wrong");
    a_pop_cause: assert property (ancPop && $past(clkEn) |->
        $past(rdEn && regAddr == ADDR_ANCILLARY && ancValid)) else $error("stray pop");
    a_flag_follow: assert property (clkEn |=>
        ancillaryAvailableFlag == $past(ancValid)) else $error("flag not tracking");
    a_left_update: assert property (wrEn && regAddr == ADDR_VOLUME_LEFT ##1
        clkEn && decStep && !wrEn |=> leftLevel == $past(regWdata[4:0], 2))
        else $error("left level not applied");
    a_level_hold: assert property (!(clkEn && decStep) |=> $stable(leftLevel))
        else $error("left level moved without step");
    a_div_gap: assert property (decClkEn && clkEn && !wrEn && divReg != 5'h00 |=>
        !decClkEn) else $error("divider pulse too long");
    a_div_period: assert property (decClkEn && clkEn && !wrEn && divReg == 5'h02
        ##1 (clkEn && !wrEn) [*2] |=> decClkEn) else $error("divider period wrong");
endmodule : mp3_ctrl_monitor

bind mp3_decoder_control_regs mp3_ctrl_monitor u_mon (
    .clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .regSel(regSel), .regWr(regWr),
    .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .ancValid(ancValid), .ancByte(ancByte), .ancPop(ancPop), .decStep(decStep),
    .leftLevel(leftLevel), .ancillaryAvailableFlag(ancillaryAvailableFlag),
    .decClkEn(decClkEn)
);

// *** verif/testbench.sv ***
`timescale 1ns/1ps
// ****
// Self-checking bench for the control register bank
// ****
module testbench
    import mp3_ctrl_pkg::*;
;
    logic       clk_sys = 1'h0, rstn = 1'h0, clkEn = 1'h1, regSel = 1'h0, regWr = 1'h0;
    logic       regRd = 1'h0, ancValid = 1'h0, decStep = 1'h0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, ancByte = 8'h00, regRdata, got;
    logic [4:0] leftLevel, rightLevel, lowBandGain, midBandGain, highBandGain;
    logic       ancPop, ancillaryAvailableFlag, decClkEn;
    int         fails = 0, cmp_count = 0, n;
    logic [7:0] rwAddr [6] = '{ADDR_VOLUME_LEFT, ADDR_VOLUME_RIGHT, ADDR_BASS_GAIN,
                               ADDR_MEDIUM_GAIN, ADDR_TREBLE_GAIN, ADDR_CLOCK_DIVIDER};
    always #25 clk_sys = ~clk_sys;
    mp3_decoder_control_regs uut (
        .clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .regSel(regSel), .regWr(regWr),
        .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .ancValid(ancValid), .ancByte(ancByte), .ancPop(ancPop), .decStep(decStep),
        .leftLevel(leftLevel), .rightLevel(rightLevel), .lowBandGain(lowBandGain),
        .midBandGain(midBandGain), .highBandGain(highBandGain),
        .ancillaryAvailableFlag(ancillaryAvailableFlag), .decClkEn(decClkEn)
    );
    task chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // One register cycle; a read leaves its data in got
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        {regSel, regWr, regRd, regAddr, regWdata} = {1'h1, w, !w, a, d};
        @(posedge clk_sys) #1;
        {regSel, regWr, regRd} = 3'h0;
        got = regRdata;
    endtask : bus
    task s_regs;
        for (int i = 0; i < 6; i++)
        begin
            bus(1'h0, rwAddr[i], 8'h00);
            chk(got, 8'h00);
            bus(1'h1, rwAddr[i], 8'(i + 17));
            bus(1'h0, rwAddr[i], 8'h00);
            chk(got, 8'(i + 17));
        end
        bus(1'h0, 8'h10, 8'h00);
        chk(got, 8'h00);
    endtask : s_regs
    // Settings reach the datapath only on a decoder step
    task s_levels;
        bus(1'h1, ADDR_VOLUME_LEFT, 8'h15);
        decStep = 1'h1;
        @(posedge clk_sys) #1;
        decStep = 1'h0;
        chk({3'h0, leftLevel}, 8'h15);
        chk({3'h0, rightLevel}, 8'h12);
        chk({3'h0, lowBandGain}, 8'h13);
        chk({3'h0, midBandGain}, 8'h14);
        chk({3'h0, highBandGain}, 8'h15);
        bus(1'h1, ADDR_VOLUME_LEFT, 8'h03);
        chk({3'h0, leftLevel}, 8'h15);
    endtask : s_levels
    task s_anc;
        {ancValid, ancByte} = {1'h1, 8'hA5};
        bus(1'h1, ADDR_ANCILLARY, 8'h5A);
        bus(1'h0, ADDR_ANCILLARY, 8'h00);
        chk(got, 8'hA5);
        chk({6'h00, ancPop, ancillaryAvailableFlag}, 8'h03);
        ancValid = 1'h0;
        bus(1'h0, ADDR_ANCILLARY, 8'h00);
        chk(got, 8'h00);
        chk({6'h00, ancPop, ancillaryAvailableFlag}, 8'h00);
    endtask : s_anc
    // With the enable low nothing is taken and read data and settings hold
    task s_freeze;
        bus(1'h0, ADDR_BASS_GAIN, 8'h00);
        clkEn = 1'h0;
        bus(1'h1, ADDR_VOLUME_LEFT, 8'h09);
        bus(1'h0, ADDR_VOLUME_LEFT, 8'h00);
        chk(got, 8'h13);
        decStep = 1'h1;
        @(posedge clk_sys) #1;
        decStep = 1'h0;
        chk({3'h0, leftLevel}, 8'h15);
        clkEn = 1'h1;
        bus(1'h0, ADDR_VOLUME_LEFT, 8'h00);
        chk(got, 8'h03);
    endtask : s_freeze
    // Reset in mid-run clears fields and outputs; divider value 0 pulses every cycle
    task s_reset;
        rstn = 1'h0;
        @(posedge clk_sys) #1;
        chk({3'h0, leftLevel}, 8'h00);
        chk(regRdata, 8'h00);
        chk({6'h00, decClkEn, ancillaryAvailableFlag}, 8'h00);
        rstn = 1'h1;
        bus(1'h0, ADDR_CLOCK_DIVIDER, 8'h00);
        chk(got, 8'h00);
        chk({7'h00, decClkEn}, 8'h01);
    endtask : s_reset
    // Slack first: the counter may wrap once after the value shrinks
    task s_div;
        bus(1'h1, ADDR_CLOCK_DIVIDER, 8'h02);
        n = 0;
        repeat (4) @(posedge clk_sys);
        repeat (9)
        begin
            @(posedge clk_sys) #1;
            n += int'(decClkEn);
        end
        chk(8'(n), 8'h03);
    endtask : s_div
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (3) @(posedge clk_sys) #1;
        rstn = 1'h1;
        s_regs;
        s_levels;
        s_anc;
        s_div;
        s_freeze;
        s_reset;
        report_and_stop;
    end
    initial
    begin
        #50000;
        fails++;
        report_and_stop;
    end
endmodule : testbench
